//--- hdl/cs0g_top.sv
/*
 * Socket 0 io-write gating and card input conditioning with an
 * AXI4-Lite register slave.
 * Assumes one 125 MHz clock; card pins asynchronous; the pad ring
 * resolves the io-write output from its enable.
 */
`timescale 1ns/1ns
`include "cs0g_defines.svh"
module cs0g_top (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [`CS0G_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`CS0G_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic host_io_write_n,
    output logic sock0_io_write_n_o,
    output logic sock0_io_write_n_oe,
    input wire logic sock0_wait_in_n,
    output logic host_wait_n,
    input wire logic sock0_io16_in_n,
    output logic host_io16_n,
    input wire logic sock0_ready_irq,
    input wire logic sock0_bvd2_speaker,
    input wire logic sock0_bvd1_status_change,
    input wire logic [1:0] sock0_voltage_sense_n,
    input wire logic [1:0] sock0_card_detect_n,
    output logic [`CS0G_PWR_W-1:0] card_power_select,
    output logic irq
);
    cs0g_sync_if sif ();
    cs0g_pkg::cs0g_bus_state_t wr_state;
    cs0g_pkg::cs0g_bus_state_t next_wr_state;
    cs0g_pkg::cs0g_bus_state_t rd_state;
    cs0g_pkg::cs0g_bus_state_t next_rd_state;

    logic [31:0] card_iface_control;
    logic [31:0] next_card_iface_control;
    logic [31:0] card_sleep_state;
    logic [31:0] next_card_sleep_state;
    logic socket_select;
    logic next_socket_select;
    logic [`CS0G_PWR_W-1:0] next_power;
    logic [`CS0G_ADDR_W-1:0] aw_addr;
    logic [`CS0G_ADDR_W-1:0] next_aw_addr;
    logic aw_have;
    logic next_aw_have;
    logic [31:0] w_data;
    logic [31:0] next_w_data;
    logic [3:0] w_strb;
    logic [3:0] next_w_strb;
    logic w_have;
    logic next_w_have;
    logic [1:0] next_bresp;
    logic [31:0] next_rdata;
    logic [1:0] next_rresp;
    logic do_write;
    logic [31:0] merged;
    logic [`CS0G_ST_W-1:0] status_word;
    logic [`CS0G_IRQ_W-1:0] irq_status;
    logic [`CS0G_IRQ_W-1:0] irq_enable;
    logic [`CS0G_IRQ_W-1:0] irq_events;
    logic clr_we;
    logic en_we;
    logic next_iow_o;
    logic next_iow_oe;
    logic next_wait;
    logic next_io16;
    logic detect_valid;
    logic wait_s1;
    logic wait_s2;
    logic wait_s3;
    logic wait_held;
    logic next_wait_held;

    // [RL12] card inputs into the synchroniser
    assign sif.raw = {sock0_io16_in_n, sock0_ready_irq, sock0_bvd2_speaker,
                      sock0_bvd1_status_change, sock0_voltage_sense_n,
                      sock0_card_detect_n[0] & sock0_card_detect_n[1] ? 1'b1 :
                      (sock0_card_detect_n[0] | sock0_card_detect_n[1])};

    cs0g_sync u_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .bus(sif.sync)
    );

    // [RL10] valid is 0 only when both detects low
    assign detect_valid = sif.synced[0];
    // [RL5] [RL6] [RL7] [RL8] [RL9] status word
    assign status_word[`CS0G_ST_IO16] = sif.synced[6];
    assign status_word[`CS0G_ST_READY] = sif.synced[5];
    assign status_word[`CS0G_ST_BVD2] = sif.synced[4];
    assign status_word[`CS0G_ST_BVD1] = sif.synced[3];
    assign status_word[`CS0G_ST_VS_LO] = sif.synced[1];
    assign status_word[`CS0G_ST_VS_HI] = sif.synced[2];
    assign status_word[`CS0G_ST_DETVAL] = detect_valid;

    // [RL6] [RL8] [RL10] interrupt sources on any change
    assign irq_events[`CS0G_IRQ_READY] = sif.changed[5];
    assign irq_events[`CS0G_IRQ_BVD1] = sif.changed[3];
    assign irq_events[`CS0G_IRQ_DETVAL] = sif.changed[0];

    assign clr_we = do_write && aw_addr == `CS0G_OFF_IRQ_CLR;
    assign en_we = do_write && aw_addr == `CS0G_OFF_IRQ_EN;

    cs0g_irq u_irq (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .event_pulse(irq_events),
        .clear_we(clr_we),
        .clear_bits(merged[`CS0G_IRQ_W-1:0]),
        .enable_we(en_we),
        .enable_bits(merged[`CS0G_IRQ_W-1:0]),
        .status(irq_status),
        .enable(irq_enable),
        .irq(irq)
    );

    // wait is a timing pin, not status: own three-stage path
    always_comb begin
        next_wait_held = (wait_s2 == wait_s3) ? wait_s3 : wait_held;
    end

    // io-write gating; card detect uses synced levels
    always_comb begin
        next_iow_o = 1'b1;
        next_iow_oe = 1'b0;
        if (card_iface_control[`CS0G_CTRL_EN_BIT]) begin
            if (card_sleep_state[`CS0G_SLEEP_MODE_BIT]) begin
                // [RL2] sleep float or high
                next_iow_oe = card_sleep_state[`CS0G_SLEEP_DRIVE_BIT];
            end else begin
                // [RL3] copy host strobe when seated
                next_iow_oe = 1'b1;
                if (!detect_valid && !socket_select) begin
                    next_iow_o = host_io_write_n;
                end
            end
        end
        // [RL1] disabled leaves output enable low
        // [RL4] host wait from socket wait
        next_wait = wait_held;
        // [RL5] host io16 from socket io16
        next_io16 = sif.synced[6];
    end

    // bus write: address and data in either order
    always_comb begin
        next_aw_addr = aw_addr;
        next_aw_have = aw_have;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_w_have = w_have;
        next_wr_state = wr_state;
        next_bresp = s_axi_bresp;
        do_write = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_addr = s_axi_awaddr;
            next_aw_have = 1'b1;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
            next_w_have = 1'b1;
        end
        unique case (wr_state)
            cs0g_pkg::CS0G_IDLE: begin
                if (aw_have && w_have) begin
                    do_write = 1'b1;
                    next_aw_have = 1'b0;
                    next_w_have = 1'b0;
                    next_wr_state = cs0g_pkg::CS0G_RESP;
                    unique case (aw_addr)
                        `CS0G_OFF_CTRL, `CS0G_OFF_SLEEP, `CS0G_OFF_IRQ_CLR,
                        `CS0G_OFF_IRQ_EN, `CS0G_OFF_PORTA, `CS0G_OFF_SEL:
                            next_bresp = `CS0G_RESP_OKAY;
                        default: next_bresp = `CS0G_RESP_SLVERR;
                    endcase
                end
            end
            cs0g_pkg::CS0G_RESP: begin
                if (s_axi_bready) begin
                    next_wr_state = cs0g_pkg::CS0G_IDLE;
                end
            end
            default: next_wr_state = cs0g_pkg::CS0G_IDLE;
        endcase
    end

    genvar b;
    generate
        for (b = 0; b < 4; b++) begin : g_lane
            always_comb begin
                unique case (aw_addr)
                    `CS0G_OFF_CTRL: merged[b*8+:8] = w_strb[b] ? w_data[b*8+:8] :
                        card_iface_control[b*8+:8];
                    `CS0G_OFF_SLEEP: merged[b*8+:8] = w_strb[b] ? w_data[b*8+:8] :
                        card_sleep_state[b*8+:8];
                    default: merged[b*8+:8] = w_strb[b] ? w_data[b*8+:8] : 8'h00;
                endcase
            end
        end
    endgenerate

    always_comb begin
        next_card_iface_control = card_iface_control;
        next_card_sleep_state = card_sleep_state;
        next_socket_select = socket_select;
        next_power = card_power_select;
        if (do_write) begin
            unique case (aw_addr)
                `CS0G_OFF_CTRL: next_card_iface_control = merged;
                `CS0G_OFF_SLEEP: next_card_sleep_state = merged;
                `CS0G_OFF_SEL: next_socket_select = merged[`CS0G_SEL_BIT];
                // [RL11] power select on port A
                `CS0G_OFF_PORTA: next_power = merged[`CS0G_PWR_W-1:0];
                default: next_power = card_power_select;
            endcase
        end
    end

    // bus read
    always_comb begin
        next_rd_state = rd_state;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        unique case (rd_state)
            cs0g_pkg::CS0G_IDLE: begin
                if (s_axi_arvalid) begin
                    next_rd_state = cs0g_pkg::CS0G_RESP;
                    next_rresp = `CS0G_RESP_OKAY;
                    next_rdata = 32'h0000_0000;
                    unique case (s_axi_araddr)
                        `CS0G_OFF_CTRL: next_rdata = card_iface_control;
                        `CS0G_OFF_SLEEP: next_rdata = card_sleep_state;
                        `CS0G_OFF_STATUS: next_rdata[`CS0G_ST_W-1:0] = status_word;
                        `CS0G_OFF_IRQ_STAT: next_rdata[`CS0G_IRQ_W-1:0] = irq_status;
                        `CS0G_OFF_IRQ_CLR: next_rdata = 32'h0000_0000;
                        `CS0G_OFF_IRQ_EN: next_rdata[`CS0G_IRQ_W-1:0] = irq_enable;
                        `CS0G_OFF_PORTA: next_rdata[`CS0G_PWR_W-1:0] = card_power_select;
                        `CS0G_OFF_SEL: next_rdata[`CS0G_SEL_BIT] = socket_select;
                        default: next_rresp = `CS0G_RESP_SLVERR;
                    endcase
                end
            end
            cs0g_pkg::CS0G_RESP: begin
                if (s_axi_rready) begin
                    next_rd_state = cs0g_pkg::CS0G_IDLE;
                end
            end
            default: next_rd_state = cs0g_pkg::CS0G_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_state <= cs0g_pkg::CS0G_IDLE;
            rd_state <= cs0g_pkg::CS0G_IDLE;
            aw_addr <= '0;
            aw_have <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            w_have <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CS0G_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `CS0G_RESP_OKAY;
            s_axi_rdata <= 32'h0000_0000;
            card_iface_control <= `CS0G_CTRL_RST;
            card_sleep_state <= `CS0G_SLEEP_RST;
            socket_select <= 1'b0;
            card_power_select <= `CS0G_PORTA_RST;
            sock0_io_write_n_o <= 1'b1;
            sock0_io_write_n_oe <= 1'b0;
            host_wait_n <= 1'b1;
            host_io16_n <= 1'b1;
            wait_s1 <= 1'b1;
            wait_s2 <= 1'b1;
            wait_s3 <= 1'b1;
            wait_held <= 1'b1;
        end else begin
            wr_state <= next_wr_state;
            rd_state <= next_rd_state;
            aw_addr <= next_aw_addr;
            aw_have <= next_aw_have;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            w_have <= next_w_have;
            // one write in flight: hold off while a slot is full
            s_axi_awready <= !next_aw_have && !s_axi_awready && next_wr_state == cs0g_pkg::CS0G_IDLE;
            s_axi_wready <= !next_w_have && !s_axi_wready && next_wr_state == cs0g_pkg::CS0G_IDLE;
            s_axi_bvalid <= next_wr_state == cs0g_pkg::CS0G_RESP;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= rd_state == cs0g_pkg::CS0G_IDLE && s_axi_arvalid;
            s_axi_rvalid <= next_rd_state == cs0g_pkg::CS0G_RESP;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
            card_iface_control <= next_card_iface_control;
            card_sleep_state <= next_card_sleep_state;
            socket_select <= next_socket_select;
            card_power_select <= next_power;
            sock0_io_write_n_o <= next_iow_o;
            sock0_io_write_n_oe <= next_iow_oe;
            host_wait_n <= next_wait;
            host_io16_n <= next_io16;
            wait_s1 <= sock0_wait_in_n;
            wait_s2 <= wait_s1;
            wait_s3 <= wait_s2;
            wait_held <= next_wait_held;
        end
    end
endmodule

//--- common/cs0g_defines.svh
/*
 * Constants for the socket 0 signal gating block: register offsets,
 * field positions, reset values.
 * Assumes inclusion by bare name from design files.
 */
// Notes on behaviour
// [RL1] Enable bit 2 clear: io-write strobe floats.
// [RL2] Asleep: float if sleep bit0 0, else high.
// [RL3] Awake: copy host strobe if detect 00, select 0.
// [RL4] Host wait follows socket wait input.
// [RL5] Host io16 follows io16; level readable.
// [RL6] Ready/irq readable and an interrupt source.
// [RL7] Bvd2/speaker level readable in status.
// [RL8] Bvd1/status-change readable and interrupt source.
// [RL9] Both voltage-sense inputs readable in status.
// [RL10] Detect valid 0 when both detects low.
// [RL11] Power select driven on port A 3:0.
// [RL12] Card inputs synchronised before status logic.
`ifndef CS0G_DEFINES_SVH
`define CS0G_DEFINES_SVH

`define CS0G_ADDR_W 8
`define CS0G_OFF_CTRL 8'h00
`define CS0G_OFF_SLEEP 8'h04
`define CS0G_OFF_STATUS 8'h08
`define CS0G_OFF_IRQ_STAT 8'h0c
`define CS0G_OFF_IRQ_CLR 8'h10
`define CS0G_OFF_IRQ_EN 8'h14
`define CS0G_OFF_PORTA 8'h18
`define CS0G_OFF_SEL 8'h1c

`define CS0G_CTRL_EN_BIT 2
`define CS0G_SLEEP_DRIVE_BIT 0
`define CS0G_SEL_BIT 0
`define CS0G_SLEEP_MODE_BIT 1

`define CS0G_ST_IO16 0
`define CS0G_ST_READY 1
`define CS0G_ST_BVD2 2
`define CS0G_ST_BVD1 3
`define CS0G_ST_VS_LO 4
`define CS0G_ST_VS_HI 5
`define CS0G_ST_DETVAL 6
`define CS0G_ST_W 7

`define CS0G_IRQ_READY 0
`define CS0G_IRQ_BVD1 1
`define CS0G_IRQ_DETVAL 2
`define CS0G_IRQ_W 3

`define CS0G_CTRL_RST 32'h0000_0000
`define CS0G_SLEEP_RST 32'h0000_0000
`define CS0G_PORTA_RST 4'h0
`define CS0G_PWR_W 4
`define CS0G_RESP_OKAY 2'b00
`define CS0G_RESP_SLVERR 2'b10

`endif

//--- common/cs0g_pkg.sv
/*
 * Types for the socket 0 signal gating block.
 * Assumes the defines header is compiled alongside.
 */
package cs0g_pkg;
    typedef enum logic [1:0] {
        CS0G_IDLE,
        CS0G_RESP
    } cs0g_bus_state_t;
endpackage

//--- common/cs0g_sync_if.sv
/*
 * Bundle of raw card inputs and their synchronised copies.
 * Assumes a single core clock shared by both ends.
 */
`timescale 1ns/1ns
interface cs0g_sync_if;
    logic [6:0] raw;
    logic [6:0] synced;
    logic [6:0] changed;
    modport sync (input raw, output synced, output changed);
    modport user (output raw, input synced, input changed);
endinterface

//--- hdl/cs0g_sync.sv
/*
 * Three-stage synchroniser per card input; a change counts once
 * stages two and three agree.
 * Assumes inputs are asynchronous to core_clk.
 */
`timescale 1ns/1ns
`include "cs0g_defines.svh"
module cs0g_sync (
    input wire logic core_clk,
    input wire logic reset_n,
    cs0g_sync_if.sync bus
);
    logic [6:0] s1;
    logic [6:0] s2;
    logic [6:0] s3;
    logic [6:0] held;
    logic [6:0] next_held;
    logic [6:0] chg;
    logic [6:0] next_chg;

    genvar i;
    generate
        for (i = 0; i < 7; i++) begin : g_bit
            // stage one is read by stage two alone
            always_comb begin
                next_held[i] = (s2[i] == s3[i]) ? s3[i] : held[i];
                next_chg[i] = (s2[i] == s3[i]) && (s3[i] != held[i]);
            end
        end
    endgenerate

    // [RL12] three-stage sync
    // reset to the idle-high pin level: no false edge after reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s1 <= 7'h7f;
            s2 <= 7'h7f;
            s3 <= 7'h7f;
            held <= 7'h7f;
            chg <= 7'h00;
        end else begin
            s1 <= bus.raw;
            s2 <= s1;
            s3 <= s2;
            held <= next_held;
            chg <= next_chg;
        end
    end

    assign bus.synced = held;
    assign bus.changed = chg;
endmodule

//--- hdl/cs0g_irq.sv
/*
 * Sticky interrupt status, enable and write-one-to-clear.
 * Assumes event pulses and clear strobes on core_clk.
 */
`timescale 1ns/1ns
`include "cs0g_defines.svh"
module cs0g_irq (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [`CS0G_IRQ_W-1:0] event_pulse,
    input wire logic clear_we,
    input wire logic [`CS0G_IRQ_W-1:0] clear_bits,
    input wire logic enable_we,
    input wire logic [`CS0G_IRQ_W-1:0] enable_bits,
    output logic [`CS0G_IRQ_W-1:0] status,
    output logic [`CS0G_IRQ_W-1:0] enable,
    output logic irq
);
    logic [`CS0G_IRQ_W-1:0] next_status;
    logic [`CS0G_IRQ_W-1:0] next_enable;
    logic next_irq;

    always_comb begin
        // set beats a clear arriving the same cycle
        next_status = (status & ~(clear_we ? clear_bits : '0)) | event_pulse;
        next_enable = enable_we ? enable_bits : enable;
        next_irq = |(next_status & next_enable);
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            status <= '0;
            enable <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            enable <= next_enable;
            irq <= next_irq;
        end
    end
endmodule

//--- testbench/cs0g_card_model.sv
/* Card in socket 0: drives card pins, resolves io-write.
   Assumes bench sets card levels on core_clk edges. */
`timescale 1ns/1ns
module cs0g_card_model (
    input wire logic core_clk,
    input wire logic [6:0] card_vec,
    input wire logic [1:0] card_det_n,
    input wire logic io_wr_o,
    input wire logic io_wr_oe,
    output logic wait_n,
    output logic io16_n,
    output logic ready,
    output logic bvd2,
    output logic bvd1,
    output logic [1:0] vs_n,
    output logic [1:0] cd_n,
    output logic io_wr_pin
);
    logic last;
    assign {vs_n, bvd1, bvd2, ready, io16_n, wait_n} = card_vec;
    assign cd_n = card_det_n;
    // no pull-up: a floating pin keeps flipping, never a stale level
    assign io_wr_pin = io_wr_oe ? io_wr_o : ~last;
    always_ff @(posedge core_clk) last <= io_wr_pin;
endmodule

//--- testbench/cs0g_top_sva.sv
/* Port checker for the gating top.
   Assumes one clock and reset_n active low; bound after the module. */
`timescale 1ns/1ns
`include "cs0g_defines.svh"
module cs0g_top_sva (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic s_axi_awready,
    input wire logic s_axi_arready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic host_io_write_n,
    input wire logic sock0_io_write_n_o,
    input wire logic sock0_io_write_n_oe,
    input wire logic sock0_wait_in_n,
    input wire logic host_wait_n,
    input wire logic sock0_io16_in_n,
    input wire logic host_io16_n,
    input wire logic [1:0] sock0_card_detect_n,
    input wire logic [`CS0G_PWR_W-1:0] card_power_select
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // eight cycles cover sync plus output flop
    sequence wait_steady_s;
        $stable(sock0_wait_in_n) [*8];
    endsequence
    sequence io16_steady_s;
        $stable(sock0_io16_in_n) [*8];
    endsequence
    sequence card_out_s;
        (sock0_card_detect_n != 2'b00) [*8];
    endsequence
    wait_follow_a: assert property (wait_steady_s |-> host_wait_n == sock0_wait_in_n)
        else $error("host wait mismatch");
    io16_follow_a: assert property (io16_steady_s |-> host_io16_n == sock0_io16_in_n)
        else $error("host io16 mismatch");
    gate_absent_a: assert property (card_out_s |-> !sock0_io_write_n_oe || sock0_io_write_n_o)
        else $error("strobe low, no card");
    strobe_copy_a: assert property (sock0_io_write_n_oe && !sock0_io_write_n_o
        |-> !$past(host_io_write_n)) else $error("strobe low, host idle");
    power_write_a: assert property ($changed(card_power_select)
        |-> $past(s_axi_bvalid) or ##[0:2] s_axi_bvalid) else $error("power changed unwritten");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
    awready_pulse_a: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready held");
    arready_rvalid_a: assert property (s_axi_arready |-> s_axi_rvalid)
        else $error("arready no rdata");
endmodule
bind cs0g_top cs0g_top_sva u_sva (.core_clk, .reset_n, .s_axi_awready, .s_axi_arready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .host_io_write_n, .sock0_io_write_n_o, .sock0_io_write_n_oe, .sock0_wait_in_n,
    .host_wait_n, .sock0_io16_in_n, .host_io16_n, .sock0_card_detect_n, .card_power_select);

//--- testbench/cs0g_top_test.sv
/* Bench for the gating top with a card model.
   Assumes the defines header on the include path. */
`timescale 1ns/1ns
`include "cs0g_defines.svh"
module cs0g_top_test;
    logic core_clk, reset_n, awvalid, wvalid, bready, arvalid, rready, host_wr_n;
    logic awready, wready, bvalid, arready, rvalid, io_o, io_oe, wait_h, io16_h, irq;
    logic c_wait, c_io16, c_ready, c_bvd2, c_bvd1, io_pin;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed, rd;
    logic [3:0] wstrb, pwr;
    logic [1:0] bresp, rresp, resp, cd, c_vs, c_cd, ep;
    logic [6:0] card;
    int n_mismatch, n_compared, cycles;

    cs0g_top uut (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .host_io_write_n(host_wr_n), .sock0_io_write_n_o(io_o),
        .sock0_io_write_n_oe(io_oe), .sock0_wait_in_n(c_wait), .host_wait_n(wait_h),
        .sock0_io16_in_n(c_io16), .host_io16_n(io16_h), .sock0_ready_irq(c_ready),
        .sock0_bvd2_speaker(c_bvd2), .sock0_bvd1_status_change(c_bvd1),
        .sock0_voltage_sense_n(c_vs), .sock0_card_detect_n(c_cd),
        .card_power_select(pwr), .irq(irq));
    cs0g_card_model card_m (.core_clk(core_clk), .card_vec(card), .card_det_n(cd),
        .io_wr_o(io_o), .io_wr_oe(io_oe), .wait_n(c_wait), .io16_n(c_io16), .ready(c_ready),
        .bvd2(c_bvd2), .bvd1(c_bvd1), .vs_n(c_vs), .cd_n(c_cd), .io_wr_pin(io_pin));

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic print_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    function automatic logic [31:0] exp_status(input logic [6:0] c, input logic [1:0] d);
        return {25'h0, d != 2'b00, c[6:1]};
    endfunction

    // {drive enable, level}
    function automatic logic [1:0] exp_pin(input logic en, input logic slp, input logic drv,
        input logic [1:0] d, input logic sel, input logic h);
        if (!en) return 2'b01;
        if (slp) return {drv, 1'b1};
        return {1'b1, (d == 2'b00 && !sel) ? h : 1'b1};
    endfunction

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
        logic aw_d, w_d;
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(aw_d && w_d)) begin
            @(posedge core_clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            aw_d = aw_d | (awready === 1'b1);
            w_d = w_d | (wready === 1'b1);
        end
        while (bvalid !== 1'b1) @(posedge core_clk);
        bready <= 1'b1;
        @(posedge core_clk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge core_clk);
        rready <= 1'b1;
        @(posedge core_clk);
        rd = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
        axi_read(a);
        check(nm, e, rd);
    endtask

    initial begin
        reset_n = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hf;
        host_wr_n = 1'b1;
        card = 7'h7f;
        cd = 2'b11;
        seed = 32'h94a4d016;
        tick(5);
        check("io_oe", 32'h0, io_oe);
        check("power", 32'h0, pwr);
        reset_n <= 1'b1;
        tick(1);
        rd_chk(`CS0G_OFF_CTRL, `CS0G_CTRL_RST, "ctrl");
        rd_chk(`CS0G_OFF_SLEEP, `CS0G_SLEEP_RST, "sleep");
        axi_read(8'h20);
        check("rd_resp", `CS0G_RESP_SLVERR, resp);
        check("rd_data", 32'h0, rd);
        axi_write(8'h20, 32'hffff_ffff);
        check("wr_resp", `CS0G_RESP_SLVERR, resp);
        rd_chk(`CS0G_OFF_PORTA, 32'h0, "porta");
        seed = xs(seed);
        axi_write(`CS0G_OFF_PORTA, {28'h0, seed[3:0]});
        check("power", {28'h0, seed[3:0]}, pwr);
        rd_chk(`CS0G_OFF_PORTA, {28'h0, seed[3:0]}, "porta");
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            card <= (i == 0) ? 7'h7f : (i == 1) ? 7'h00 : seed[6:0];
            cd <= (i == 0) ? 2'b11 : (i == 1) ? 2'b00 : seed[8:7];
            tick(8);
            rd_chk(`CS0G_OFF_STATUS, exp_status(card, cd), "status");
            check("host_wait_n", {31'h0, card[0]}, wait_h);
            check("host_io16_n", {31'h0, card[1]}, io16_h);
        end
        for (int i = 0; i < 32; i++) begin
            seed = xs(seed);
            cd <= i[4] ? 2'b00 : (seed[1:0] == 2'b00) ? 2'b10 : seed[1:0];
            axi_write(`CS0G_OFF_CTRL, 32'(i[0]) << `CS0G_CTRL_EN_BIT);
            axi_write(`CS0G_OFF_SLEEP, {30'h0, i[1], i[2]});
            axi_write(`CS0G_OFF_SEL, {31'h0, i[3]});
            tick(8);
            repeat (2) begin
                seed = xs(seed);
                host_wr_n <= seed[0];
                tick(2);
                ep = exp_pin(i[0], i[1], i[2], cd, i[3], host_wr_n);
                check("io_oe", {31'h0, ep[1]}, io_oe);
                if (ep[1]) check("io_pin", {31'h0, ep[0]}, io_pin);
            end
        end
        card <= 7'h00;
        cd <= 2'b11;
        tick(8);
        axi_write(`CS0G_OFF_IRQ_CLR, 32'h7);
        axi_write(`CS0G_OFF_IRQ_EN, 32'h7);
        rd_chk(`CS0G_OFF_IRQ_STAT, 32'h0, "irq_stat");
        check("irq", 32'h0, irq);
        card <= 7'h14;
        cd <= 2'b00;
        tick(8);
        rd_chk(`CS0G_OFF_IRQ_STAT, 32'h7, "irq_stat");
        check("irq", 32'h1, irq);
        axi_write(`CS0G_OFF_IRQ_EN, 32'h0);
        tick(2);
        check("irq", 32'h0, irq);
        axi_write(`CS0G_OFF_IRQ_CLR, 32'h1);
        rd_chk(`CS0G_OFF_IRQ_STAT, 32'h6, "irq_stat");
        rd_chk(`CS0G_OFF_IRQ_CLR, 32'h0, "irq_clr");
        axi_write(`CS0G_OFF_IRQ_EN, 32'h7);
        tick(2);
        check("irq", 32'h1, irq);
        axi_write(`CS0G_OFF_IRQ_CLR, 32'h6);
        tick(2);
        check("irq", 32'h0, irq);
        print_verdict();
    end
endmodule
